//--- maxi_top.sv
// design: per-axis io status, position counters and interrupt logic
// ============================================================
// Functional notes
// - drive enable pin follows software bit
// - status bits 0-5: limits, slowdowns, origin, index
// - status bits 6-11: fault, enable, ready, int, clear, inpos
// - status bit one when signal on per polarity
// - actual position write loads counter
// - encoder disabled: actual read returns command
// - command position write overwrites, read returns value
// - card enable gates interrupt to host
// - 32-bit mask gates each factor except compare
// - mask 0-3: limit, slowdown, fault, stop
// - mask 5-7: home, preset, interpolation done
// - mask 13-15: velocity stop, encoder error, go
// - mask 16,17,23: accel end, decel start, ready
// - simultaneous pair change flags encoder error
// - host can read which axis interrupts
// - 32-bit cause register clears on read
// - cause 0-5: limit, slowdown, fault, stop stops
// - cause 6,8,9,11: compare, vstop, home, preset
// - cause 12,14-17,23 events; others zero
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module maxi_top #(
  parameter int NUM_AXES = maxi_pkg::NUM_AXES,
  parameter int POS_W = maxi_pkg::POS_W
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire maxi_pkg::maxi_pins_t [NUM_AXES-1:0] AXIS_PINS,
  input wire maxi_pkg::maxi_evt_t [NUM_AXES-1:0] AXIS_EVT,
  input wire maxi_pkg::maxi_enc_t [NUM_AXES-1:0] AXIS_ENC,
  input wire logic [NUM_AXES-1:0] ENC_STEP,
  input wire logic [NUM_AXES-1:0] ENC_DIR,
  input wire logic [NUM_AXES-1:0] CMD_STEP,
  input wire logic [NUM_AXES-1:0] CMD_DIR,
  output logic [NUM_AXES-1:0] DRIVE_ENABLE_OUT,
  output logic [NUM_AXES-1:0] DEVIATION_CLEAR_OUT,
  output logic HOST_IRQ
);
  // ============================================================
  // register decode
  logic card_sel;
  logic [NUM_AXES-1:0] ax_sel;
  logic [7:0] reg_off;
  logic card_irq_en;
  logic [31:0] ctrl [NUM_AXES];
  logic [31:0] mask [NUM_AXES];
  logic [31:0] cause [NUM_AXES];
  logic [POS_W-1:0] act_pos [NUM_AXES];
  logic [POS_W-1:0] cmd_pos [NUM_AXES];
  logic [15:0] io_word [NUM_AXES];
  logic [31:0] next_cause [NUM_AXES];
  logic [NUM_AXES-1:0] axis_pending;
  maxi_pkg::maxi_enc_t enc_prev [NUM_AXES];

  assign card_sel = (ADDR == maxi_pkg::REG_CARD);
  assign reg_off = ADDR & ~maxi_pkg::AXIS_STRIDE;

  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      ax_sel[a] = !ADDR[7] && (ADDR[6] == a[0]);
    end
  end

  // ============================================================
  // card-level interrupt enable
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      card_irq_en <= 1'b0;
    end else if (WR && card_sel) begin
      card_irq_en <= WDATA[0];
    end
  end

  // ============================================================
  // per-axis logic
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    logic [8:0] raw;
    logic [8:0] pol;
    logic [8:0] on;
    logic enc_err;
    logic hw_err;
    logic rdy_q;
    logic [31:0] evt_set;

    assign raw = AXIS_PINS[a];
    assign pol = ctrl[a][maxi_pkg::CTRL_POL_LSB +: 9];
    // polarity bit 1 means active high
    assign on = ~(raw ^ pol);

    always_comb begin
      io_word[a] = 16'h0000;
      io_word[a][0] = on[0];
      io_word[a][1] = on[1];
      io_word[a][2] = on[2];
      io_word[a][3] = on[3];
      io_word[a][4] = on[4];
      io_word[a][5] = on[5];
      io_word[a][6] = on[6];
      io_word[a][7] = DRIVE_ENABLE_OUT[a];
      io_word[a][8] = on[7];
      io_word[a][maxi_pkg::IO_INT] = axis_pending[a];
      io_word[a][10] = DEVIATION_CLEAR_OUT[a];
      io_word[a][11] = on[8];
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        ctrl[a] <= maxi_pkg::CTRL_RESET;
      end else if (WR && ax_sel[a] && reg_off == maxi_pkg::REG_CTRL) begin
        ctrl[a] <= WDATA;
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        DRIVE_ENABLE_OUT[a] <= 1'b0;
        DEVIATION_CLEAR_OUT[a] <= 1'b0;
      end else begin
        DRIVE_ENABLE_OUT[a] <= ctrl[a][maxi_pkg::CTRL_DRV_EN];
        DEVIATION_CLEAR_OUT[a] <= ctrl[a][maxi_pkg::CTRL_DEV_CLR];
      end
    end

    // unused mask bits are dropped; software should write them zero
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        mask[a] <= maxi_pkg::MASK_RESET;
      end else if (WR && ax_sel[a] && reg_off == maxi_pkg::REG_MASK) begin
        mask[a] <= WDATA & maxi_pkg::MASK_IMPL;
      end
    end

    // position counters; software write has priority over a step
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        act_pos[a] <= '0;
      end else if (WR && ax_sel[a] && reg_off == maxi_pkg::REG_ACT_POS) begin
        act_pos[a] <= WDATA[POS_W-1:0];
      end else if (ENC_STEP[a]) begin
        act_pos[a] <= ENC_DIR[a] ? act_pos[a] - 1'b1 : act_pos[a] + 1'b1;
      end
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        cmd_pos[a] <= '0;
      end else if (WR && ax_sel[a] && reg_off == maxi_pkg::REG_CMD_POS) begin
        cmd_pos[a] <= WDATA[POS_W-1:0];
      end else if (CMD_STEP[a]) begin
        cmd_pos[a] <= CMD_DIR[a] ? cmd_pos[a] - 1'b1 : cmd_pos[a] + 1'b1;
      end
    end

    // a pair whose two lines both toggle in one sample is an illegal edge;
    // the history tracks the pins through reset too, so no false edge follows it
    always_ff @(posedge CLK_SYS) begin
      enc_prev[a] <= AXIS_ENC[a];
      rdy_q <= raw[7];
    end
    assign enc_err = (AXIS_ENC[a].enc_a ^ enc_prev[a].enc_a)
                   & (AXIS_ENC[a].enc_b ^ enc_prev[a].enc_b);
    assign hw_err = (AXIS_ENC[a].hw_a ^ enc_prev[a].hw_a)
                  & (AXIS_ENC[a].hw_b ^ enc_prev[a].hw_b);

    // a factor other than compare is recorded only while its mask bit is set
    always_comb begin
      evt_set = 32'h0000_0000;
      evt_set[maxi_pkg::C_PEL] = AXIS_EVT[a].stop_pel & mask[a][maxi_pkg::M_EL];
      evt_set[maxi_pkg::C_NEL] = AXIS_EVT[a].stop_nel & mask[a][maxi_pkg::M_EL];
      evt_set[maxi_pkg::C_PSD] = AXIS_EVT[a].stop_psd & mask[a][maxi_pkg::M_SD];
      evt_set[maxi_pkg::C_NSD] = AXIS_EVT[a].stop_nsd & mask[a][maxi_pkg::M_SD];
      evt_set[maxi_pkg::C_ALM] = AXIS_EVT[a].stop_alm & mask[a][maxi_pkg::M_ALM];
      evt_set[maxi_pkg::C_STP] = AXIS_EVT[a].stop_stp & mask[a][maxi_pkg::M_STP];
      // compare interrupt has its own enable elsewhere, so it is always recorded
      evt_set[maxi_pkg::C_CMP] = AXIS_EVT[a].cmp_active;
      evt_set[maxi_pkg::C_VSTOP] = AXIS_EVT[a].stop_vstop & mask[a][maxi_pkg::M_VSTOP];
      evt_set[maxi_pkg::C_HOME] = AXIS_EVT[a].home_done & mask[a][maxi_pkg::M_HOME];
      evt_set[maxi_pkg::C_PRESET] = AXIS_EVT[a].preset_done & mask[a][maxi_pkg::M_PRESET];
      // no interpolation cause bit exists; it reports as preset completion
      evt_set[maxi_pkg::C_PRESET] = evt_set[maxi_pkg::C_PRESET]
        | (AXIS_EVT[a].interp_done & mask[a][maxi_pkg::M_INTERP]);
      evt_set[maxi_pkg::C_ENC] = enc_err & mask[a][maxi_pkg::M_ENC];
      evt_set[maxi_pkg::C_HW] = hw_err & mask[a][maxi_pkg::M_ENC];
      evt_set[maxi_pkg::C_GO] = AXIS_EVT[a].go_start & mask[a][maxi_pkg::M_GO];
      evt_set[maxi_pkg::C_ACC] = AXIS_EVT[a].acc_done & mask[a][maxi_pkg::M_ACC];
      evt_set[maxi_pkg::C_DEC] = AXIS_EVT[a].dec_start & mask[a][maxi_pkg::M_DEC];
      evt_set[maxi_pkg::C_RDY] = rdy_q & ~raw[7] & mask[a][maxi_pkg::M_RDY];
    end

    // clear on read; an event in the read cycle survives the clear
    always_comb begin
      next_cause[a] = cause[a];
      if (RD && ax_sel[a] && reg_off == maxi_pkg::REG_CAUSE) begin
        next_cause[a] = 32'h0000_0000;
      end
      next_cause[a] = next_cause[a] | evt_set;
    end

    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        cause[a] <= 32'h0000_0000;
      end else begin
        cause[a] <= next_cause[a];
      end
    end

    assign axis_pending[a] = |cause[a];
  end

  // ============================================================
  // interrupt output
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      HOST_IRQ <= 1'b0;
    end else begin
      HOST_IRQ <= card_irq_en && (|axis_pending);
    end
  end

  // ============================================================
  // read path, data valid the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= 32'h0000_0000;
      if (card_sel) begin
        RDATA <= {{(32-NUM_AXES){1'b0}}, axis_pending} << 8 | {31'h0, card_irq_en};
      end else begin
        for (int a = 0; a < NUM_AXES; a++) begin
          if (ax_sel[a]) begin
            if (reg_off == maxi_pkg::REG_IO_STATE) begin
              RDATA <= {16'h0000, io_word[a]};
            end else if (reg_off == maxi_pkg::REG_CTRL) begin
              RDATA <= ctrl[a];
            end else if (reg_off == maxi_pkg::REG_MASK) begin
              RDATA <= mask[a];
            end else if (reg_off == maxi_pkg::REG_CAUSE) begin
              RDATA <= cause[a];
            end else if (reg_off == maxi_pkg::REG_ACT_POS) begin
              RDATA <= 32'(ctrl[a][maxi_pkg::CTRL_ENC_SRC] ? act_pos[a] : cmd_pos[a]);
            end else if (reg_off == maxi_pkg::REG_CMD_POS) begin
              RDATA <= 32'(cmd_pos[a]);
            end
          end
        end
      end
    end
  end
endmodule : maxi_top

//--- maxi_pkg.sv
// package: register map, field positions and shared types of the axis io / irq block
package maxi_pkg;
  localparam int NUM_AXES = 2;
  localparam int POS_W = 28;
  // register map, word index = addr[5:2], axis selected by addr[6]
  localparam logic [7:0] REG_IO_STATE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CAUSE = 8'h0C;
  localparam logic [7:0] REG_ACT_POS = 8'h10;
  localparam logic [7:0] REG_CMD_POS = 8'h14;
  localparam logic [7:0] REG_CARD = 8'h80;
  localparam logic [7:0] AXIS_STRIDE = 8'h40;
  // control register fields
  localparam int CTRL_DRV_EN = 0;
  localparam int CTRL_ENC_SRC = 1;
  localparam int CTRL_DEV_CLR = 2;
  localparam int CTRL_POL_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // mask bits that may be written
  localparam logic [31:0] MASK_IMPL = 32'h0083_E0EF;
  // status word fields
  localparam int IO_PEL = 0;
  localparam int IO_INT = 9;
  // cause fields
  localparam int C_PEL = 0;
  localparam int C_NEL = 1;
  localparam int C_PSD = 2;
  localparam int C_NSD = 3;
  localparam int C_ALM = 4;
  localparam int C_STP = 5;
  localparam int C_CMP = 6;
  localparam int C_VSTOP = 8;
  localparam int C_HOME = 9;
  localparam int C_PRESET = 11;
  localparam int C_ENC = 12;
  localparam int C_HW = 14;
  localparam int C_GO = 15;
  localparam int C_ACC = 16;
  localparam int C_DEC = 17;
  localparam int C_RDY = 23;
  localparam int C_INTERP = 7;
  // mask fields
  localparam int M_EL = 0;
  localparam int M_SD = 1;
  localparam int M_ALM = 2;
  localparam int M_STP = 3;
  localparam int M_HOME = 5;
  localparam int M_PRESET = 6;
  localparam int M_INTERP = 7;
  localparam int M_VSTOP = 13;
  localparam int M_ENC = 14;
  localparam int M_GO = 15;
  localparam int M_ACC = 16;
  localparam int M_DEC = 17;
  localparam int M_RDY = 23;

  // raw axis inputs, as on the pins
  typedef struct packed {
    logic in_position_in;
    logic ready_input;
    logic servo_fault_in;
    logic index_pulse;
    logic origin_switch;
    logic neg_slowdown_point;
    logic pos_slowdown_point;
    logic negative_travel_limit;
    logic positive_travel_limit;
  } maxi_pins_t;

  // one-cycle event pulses from the motion core
  typedef struct packed {
    logic stop_pel;
    logic stop_nel;
    logic stop_psd;
    logic stop_nsd;
    logic stop_alm;
    logic stop_stp;
    logic cmp_active;
    logic stop_vstop;
    logic home_done;
    logic preset_done;
    logic interp_done;
    logic go_start;
    logic acc_done;
    logic dec_start;
  } maxi_evt_t;

  typedef struct packed {
    logic enc_a;
    logic enc_b;
    logic hw_a;
    logic hw_b;
  } maxi_enc_t;
endpackage : maxi_pkg

//--- maxi_monitor.sv
// checker: port-level relations of the axis io and interrupt block
`timescale 1ns/100ps
module maxi_monitor #(
  parameter int NUM_AXES = 2,
  parameter int POS_W = 28
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire maxi_pkg::maxi_pins_t [NUM_AXES-1:0] AXIS_PINS,
  input wire maxi_pkg::maxi_evt_t [NUM_AXES-1:0] AXIS_EVT,
  input wire maxi_pkg::maxi_enc_t [NUM_AXES-1:0] AXIS_ENC,
  input wire logic [NUM_AXES-1:0] CMD_STEP,
  input wire logic [NUM_AXES-1:0] DRIVE_ENABLE_OUT,
  input wire logic [NUM_AXES-1:0] DEVIATION_CLEAR_OUT,
  input wire logic HOST_IRQ
);
  // ============================================================
  // quiet counter: cycles since anything that may set a cause
  maxi_pkg::maxi_pins_t [NUM_AXES-1:0] pins_q;
  maxi_pkg::maxi_enc_t [NUM_AXES-1:0] enc_q;
  logic [3:0] quiet;
  logic [2:0] rw_hist;
  wire act = WR || AXIS_EVT != '0 || AXIS_PINS != pins_q || AXIS_ENC != enc_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLK_SYS) begin
    pins_q <= AXIS_PINS;
    enc_q <= AXIS_ENC;
    rw_hist <= {rw_hist[1:0], RD || WR};
    quiet <= (!RST_N || act) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
  end
  // ============================================================
  // assertions
  property p_ctrl_pins;
    (WR && ADDR == 8'h04) ##1 (!WR) [*3] |-> DRIVE_ENABLE_OUT[0] == $past(WDATA[0], 3)
      && DEVIATION_CLEAR_OUT[0] == $past(WDATA[2], 3);
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins) else $error("pins lag write");
  property p_io_word;
    RD && ADDR == 8'h00 && !$past(WR) && !$past(WR, 2) |=> RDATA[31:12] == '0
      && RDATA[7] == $past(DRIVE_ENABLE_OUT[0]) && RDATA[10] == $past(DEVIATION_CLEAR_OUT[0]);
  endproperty
  a_io_word: assert property (p_io_word) else $error("io word wrong");
  property p_cause_zero;
    RD && !ADDR[7] && ADDR[5:0] == 6'h0C |=> (RDATA & 32'hFF7C_2480) == '0;
  endproperty
  a_cause_zero: assert property (p_cause_zero) else $error("spare cause bit set");
  property p_mask_impl;
    RD && !ADDR[7] && ADDR[5:0] == 6'h08 |=> (RDATA & ~maxi_pkg::MASK_IMPL) == '0;
  endproperty
  a_mask_impl: assert property (p_mask_impl) else $error("spare mask bit set");
  property p_cmd_pos;
    (WR && ADDR == 8'h14 && !CMD_STEP[0]) ##1 (!WR && !CMD_STEP[0]) ##1
      (RD && ADDR == 8'h14 && !CMD_STEP[0]) |=> RDATA[POS_W-1:0] == $past(WDATA[POS_W-1:0], 3);
  endproperty
  a_cmd_pos: assert property (p_cmd_pos) else $error("command position lost");
  property p_cause_clear;
    (RD && ADDR == 8'h0C && quiet > 4'h5 && !act) ##1 !act ##1 (RD && ADDR == 8'h0C && !act)
      |=> RDATA == '0;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause kept");
  property p_irq_rise;
    quiet > 4'h7 |-> !$rose(HOST_IRQ);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
  property p_irq_fall;
    $fell(HOST_IRQ) |-> rw_hist != 3'h0;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
endmodule : maxi_monitor

bind maxi_top maxi_monitor #(.NUM_AXES(NUM_AXES), .POS_W(POS_W)) i_mon (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .AXIS_PINS(AXIS_PINS), .AXIS_EVT(AXIS_EVT), .AXIS_ENC(AXIS_ENC), .CMD_STEP(CMD_STEP),
  .DRIVE_ENABLE_OUT(DRIVE_ENABLE_OUT), .DEVIATION_CLEAR_OUT(DEVIATION_CLEAR_OUT),
  .HOST_IRQ(HOST_IRQ));

//--- maxi_drv_model.sv
// partner model: servo drive pins, encoder and handwheel lines
`timescale 1ns/100ps
module maxi_drv_model #(
  parameter int NUM_AXES = 2
) (
  input wire logic clk,
  input wire maxi_pkg::maxi_pins_t [NUM_AXES-1:0] pins_req,
  input wire logic [NUM_AXES-1:0] step_a,
  input wire logic [NUM_AXES-1:0] both_enc,
  input wire logic [NUM_AXES-1:0] both_hw,
  output maxi_pkg::maxi_pins_t [NUM_AXES-1:0] axis_pins,
  output maxi_pkg::maxi_enc_t [NUM_AXES-1:0] axis_enc
);
  // ============================================================
  // one line moves per step unless a pair fault is asked for
  assign axis_pins = pins_req;
  initial axis_enc = '0;
  always @(posedge clk) begin
    for (int a = 0; a < NUM_AXES; a++) begin
      axis_enc[a] <= axis_enc[a] ^ {step_a[a] | both_enc[a], both_enc[a], {2{both_hw[a]}}};
    end
  end
endmodule : maxi_drv_model

//--- tb_top.sv
// testbench: register, pin and interrupt scenarios for the axis io block
`timescale 1ns/100ps
module tb_top;
  logic CLK_SYS, RST_N, WR, RD, irq;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA;
  logic [1:0] de, dc, st_a, be, bh, es, ed, cs, cd;
  maxi_pkg::maxi_pins_t [1:0] pins, pin_w;
  maxi_pkg::maxi_evt_t [1:0] evt;
  maxi_pkg::maxi_enc_t [1:0] enc_w;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int cbit[14] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 11, 11, 15, 16, 17};
  maxi_top i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .AXIS_PINS(pin_w), .AXIS_EVT(evt), .AXIS_ENC(enc_w),
    .ENC_STEP(es), .ENC_DIR(ed), .CMD_STEP(cs), .CMD_DIR(cd),
    .DRIVE_ENABLE_OUT(de), .DEVIATION_CLEAR_OUT(dc), .HOST_IRQ(irq));
  maxi_drv_model i_drv (.clk(CLK_SYS), .pins_req(pins), .step_a(st_a), .both_enc(be),
    .both_hw(bh), .axis_pins(pin_w), .axis_enc(enc_w));
  // ============================================================
  // bus and checking tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 chk(s, RDATA, exp);
  endtask : rchk
  // events need a few idle cycles so causes settle before the read
  task automatic fire(input int k);
    @(posedge CLK_SYS);
    evt[1] <= maxi_pkg::maxi_evt_t'(14'h1 << k);
    @(posedge CLK_SYS);
    evt[1] <= '0;
    repeat (6) @(posedge CLK_SYS);
    #1;
  endtask : fire
  task automatic poke(input int w, input logic [31:0] exp);
    @(posedge CLK_SYS);
    {bh[0], be[0], st_a[0]} <= 3'(w);
    @(posedge CLK_SYS);
    {bh[0], be[0], st_a[0]} <= 3'h0;
    repeat (6) @(posedge CLK_SYS);
    rchk("pair", 8'h0C, exp);
  endtask : poke
  function automatic logic [31:0] io_exp(logic [8:0] p, logic [8:0] pol, logic en, logic clr);
    logic [8:0] on;
    on = p ~^ pol;
    return {20'h0, on[8], clr, 1'b0, on[7], en, on[6:0]};
  endfunction : io_exp
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ============================================================
  // clock, timeout and scenarios
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    {RST_N, WR, RD, ADDR, WDATA, evt, st_a, be, bh, es, ed, cs, cd} = '0;
    pins = '0;
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rchk("ctrl", 8'h04, maxi_pkg::CTRL_RESET);
    rchk("mask", 8'h48, maxi_pkg::MASK_RESET);
    rchk("void", 8'hFC, 32'h0);
    @(posedge CLK_SYS);
    pins <= {9'h15A, 9'h0A5};
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h04 + 8'(a * 64), {15'h0, {9{p[0]}}, 5'h0, !p[0], 1'b1, p[0]});
        repeat (3) @(posedge CLK_SYS);
        #1 chk("drive", {30'h0, de[a], dc[a]}, {30'h0, p[0], !p[0]});
        rchk("io", 8'(a * 64), io_exp(pins[a], {9{p[0]}}, p[0], !p[0]));
      end
    end
    wr(8'h14, 32'hFABC_DEF1);
    rchk("cmd", 8'h14, 32'h0ABC_DEF1);
    wr(8'h10, 32'h0123_4567);
    rchk("act", 8'h10, 32'h0123_4567);
    wr(8'h04, 32'h0000_0004);
    rchk("act src", 8'h10, 32'h0ABC_DEF1);
    // one command step up and one encoder step down, then both read back
    @(posedge CLK_SYS);
    {cs[0], cd[0], es[0], ed[0]} <= 4'hB;
    @(posedge CLK_SYS);
    {cs[0], cd[0], es[0], ed[0]} <= 4'h0;
    rchk("cmd step", 8'h14, 32'h0ABC_DEF2);
    wr(8'h04, 32'h0000_0006);
    rchk("act step", 8'h10, 32'h0123_4566);
    wr(8'h80, 32'h1);
    wr(8'h48, 32'h0083_E0EF);
    rchk("mask", 8'h48, maxi_pkg::MASK_IMPL);
    for (int i = 0; i < 14; i++) begin
      fire(13 - i);
      // compare activity has no factor bit, so its request is not judged
      if (i != 6) begin
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("which", 8'h80, 32'h201);
      end
      rchk("cause", 8'h4C, 32'h1 << cbit[i]);
      rchk("clear", 8'h4C, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    wr(8'h48, 32'h0000_0020);
    fire(4);
    rchk("masked", 8'h4C, 32'h0);
    wr(8'h80, 32'h0);
    fire(5);
    chk("blocked", {31'h0, irq}, 32'h0);
    wr(8'h80, 32'h1);
    repeat (3) @(posedge CLK_SYS);
    #1 chk("unblocked", {31'h0, irq}, 32'h1);
    rchk("io int", 8'h40, io_exp(pins[1], 9'h1FF, 1'b1, 1'b0) | 32'h200);
    rchk("cause", 8'h4C, 32'h200);
    wr(8'h08, 32'h0080_4000);
    poke(1, 32'h0);
    poke(2, 32'h0000_1000);
    poke(4, 32'h0000_4000);
    @(posedge CLK_SYS);
    pins[0] <= 9'h025;
    poke(0, 32'h0080_0000);
    rchk("clear", 8'h0C, 32'h0);
    report_and_stop;
  end
endmodule : tb_top
